// *** via_pkg.sv ***
// constants and types of the vectored interrupt acceptance block
// Behaviour
// R1: a source is eligible only while its request is 1 and its mask is 0
// R2: maskable requests are accepted only while the global accept flag is 1
// R3: latency is 7..32 clocks for high level and 8..33 for low level
// R4: acceptance waits for a running divide, so latency may exceed the maximum
// R5: higher programmed level wins; on equal level the fixed default order wins
// R6: a request not yet acceptable stays pending until all conditions hold
// R7: accept pushes status word then pointer, clears accept, loads level, vectors
// R8: handlers end maskable servicing with the vectored return
// R9: break trap always pushes both, clears accept, vectors to 003eh
// R10: trap handlers return with the break return, never the vectored return
// R11: acceptance clears the accept flag; nesting needs accept-on again
// R12: while accepting, nest equal or higher level; high service nests high only
// R13: a break trap is taken during any servicing, whatever the flags
// R14: after a return one program instruction runs before a pending request
// R15: level flag is 0 in high servicing, 1 when idle or low servicing
// R16: priority bit 0 selects the high level, 1 the low level
// R17: status word, accept on/off, returns, register access defer one instruction
// R18: break defers nothing, but no maskable request is taken during it
// R19: the priority bit never affects setting of the request flag
// R20: reset sets the status word to 02h
// R21: returns and status pops restore the status word from the stack
// R22: ties go to the lowest source index; each source has a fixed vector
`default_nettype none
package via_pkg;
    // ========================================================
    // register map, byte addresses
    localparam logic [7:0]  OFS_REQ      = 8'h00;
    localparam logic [7:0]  OFS_MASK     = 8'h04;
    localparam logic [7:0]  OFS_PRIO     = 8'h08;
    localparam logic [7:0]  OFS_SW       = 8'h0c;
    localparam logic [7:0]  OFS_STAT     = 8'h10;
    // ========================================================
    // status word layout and reset
    localparam logic [7:0]  SW_RESET     = 8'h02;
    localparam int unsigned SW_IE_BIT    = 7;
    localparam int unsigned SW_ISP_BIT   = 1;
    // ========================================================
    // vectors and latency figures, in cpu clocks
    localparam logic [15:0] BRK_VEC      = 16'h003e;
    localparam logic [15:0] VEC_BASE     = 16'h0004;
    localparam int unsigned LAT_HI_MIN   = 7;
    localparam int unsigned LAT_HI_MAX   = 32;
    localparam int unsigned LAT_LO_MIN   = 8;
    localparam int unsigned LAT_LO_MAX   = 33;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
    // ========================================================
    // sequencer states and the stack push carrier
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PSW  = 2'b01,
        ST_PIP  = 2'b10,
        ST_VEC  = 2'b11
    } via_state_t;
    typedef struct packed {
        logic        valid;
        logic        is_ptr;
        logic [15:0] data;
    } via_push_t;
endpackage : via_pkg
`default_nettype wire

// *** via_core.sv ***
// vectored interrupt acceptance: flags, arbitration, push and vector sequence
`default_nettype none
module via_core #(
    parameter int unsigned N  = 16,
    parameter int unsigned SW = 4
) (
    // clock, reset, enable
    input  wire logic                MCLK,
    input  wire logic                RST,
    input  wire logic                CE,
    // ahb-lite register slave
    input  wire logic                HSEL,
    input  wire logic [31:0]         HADDR,
    input  wire logic [1:0]          HTRANS,
    input  wire logic                HWRITE,
    input  wire logic [2:0]          HSIZE,
    input  wire logic [31:0]         HWDATA,
    input  wire logic                HREADY,
    output logic                     HREADYOUT,
    output logic [31:0]              HRDATA,
    output logic                     HRESP,
    // peripheral request pulses, same clock
    input  wire logic [N-1:0]        IRQ_IN,
    // cpu instruction sequencer, sampled with INSN_DONE
    input  wire logic                INSN_DONE,
    input  wire logic                INSN_HOLD,
    input  wire logic                DIV_BUSY,
    input  wire logic                BRK_EXEC,
    input  wire logic                RETV_EXEC,
    input  wire logic                BREAK_RETURN_INSTRUCTION_EXEC,
    input  wire logic                SW_POP,
    input  wire logic [7:0]          POP_DATA,
    input  wire logic                SW_LOAD,
    input  wire logic [7:0]          SW_LOAD_DATA,
    input  wire logic                ACCEPT_ON,
    input  wire logic                ACCEPT_OFF,
    input  wire logic [15:0]         IP_IN,
    // to the cpu stack and fetch logic
    output logic                     SERVICE_BUSY,
    output via_pkg::via_push_t       PUSH,
    output logic                     VEC_VALID,
    output logic [15:0]              VEC_ADDR,
    output logic [7:0]               STATUS_WORD
);
    // ========================================================
    // state
    via_pkg::via_state_t state_r;
    logic [N-1:0]  req_r, mask_r, prio_r, req_nxt;
    logic [7:0]    sw_r, sw_nxt;
    logic          acc_hold_r, is_brk_r, sel_pr_r;
    logic [SW-1:0] sel_r;
    logic [15:0]   ip_r;
    via_pkg::via_push_t push_r;
    logic          vec_valid_r;
    logic [15:0]   vec_addr_r;
    // bus address phase
    logic [7:0]    a_addr_r;
    logic          a_wr_r, a_act_r;
    logic [31:0]   rdata_r;

    // fixed arbitration: lowest index wins among the chosen level
    function automatic logic [SW-1:0] pick_idx(input logic [N-1:0] cand);
        logic [SW-1:0] idx;
        idx = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (cand[i])
            begin
                idx = SW'(i);
            end
        end
        return idx;
    endfunction : pick_idx

    // ========================================================
    // qualification and arbitration
    logic [N-1:0]  elig, elig_hi;
    logic          any_elig, use_hi, sel_pr, hold_now;
    logic          start_brk, start_mask, start_any;
    logic [SW-1:0] sel;

    always_comb
    begin
        elig     = req_r & ~mask_r;                                // [R1]
        elig_hi  = elig & ~prio_r;                                 // [R16]
        any_elig = |elig;
        use_hi   = |elig_hi;                                       // [R5]
        sel      = use_hi ? pick_idx(elig_hi) : pick_idx(elig);    // [R5] [R22]
        sel_pr   = prio_r[sel];
        // instructions touching the status word or flags hold one instruction
        hold_now = INSN_HOLD | RETV_EXEC | BREAK_RETURN_INSTRUCTION_EXEC | SW_POP | SW_LOAD
                 | ACCEPT_ON | ACCEPT_OFF | acc_hold_r;            // [R17] [R14]
        start_brk = (state_r == via_pkg::ST_IDLE) & INSN_DONE & BRK_EXEC; // [R9] [R13]
        // a break boundary is never a maskable boundary: it clears accept
        start_mask = (state_r == via_pkg::ST_IDLE) & INSN_DONE & ~BRK_EXEC
                   & ~hold_now & ~DIV_BUSY & any_elig             // [R18] [R4] [R6]
                   & sw_r[via_pkg::SW_IE_BIT]                      // [R2] [R11]
                   & (sw_r[via_pkg::SW_ISP_BIT] | ~sel_pr);        // [R12]
        start_any = start_brk | start_mask;
    end

    // ========================================================
    // request flags: peripheral set wins over bus write and acceptance
    always_comb
    begin
        req_nxt = req_r;
        if (a_act_r && a_wr_r && a_addr_r == via_pkg::OFS_REQ)
        begin
            req_nxt = HWDATA[N-1:0];
        end
        if (start_mask)
        begin
            req_nxt[sel] = 1'b0;
        end
        req_nxt = req_nxt | IRQ_IN;                                // [R19] [R6]
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            req_r <= '0;
        end
        else if (CE)
        begin
            req_r <= req_nxt;
        end
    end

    // mask and priority, all masked and low level out of reset
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            mask_r <= '1;
            prio_r <= '1;
        end
        else if (CE && a_act_r && a_wr_r)
        begin
            if (a_addr_r == via_pkg::OFS_MASK)
            begin
                mask_r <= HWDATA[N-1:0];
            end
            else if (a_addr_r == via_pkg::OFS_PRIO)
            begin
                prio_r <= HWDATA[N-1:0];                           // [R16]
            end
        end
    end

    // ========================================================
    // status word: cpu updates only at boundaries, sequencer at vector
    always_comb
    begin
        sw_nxt = sw_r;
        if (RETV_EXEC || BREAK_RETURN_INSTRUCTION_EXEC || SW_POP)
        begin
            sw_nxt = POP_DATA;                                     // [R21]
        end
        else if (SW_LOAD)
        begin
            sw_nxt = SW_LOAD_DATA;
        end
        else if (ACCEPT_ON)
        begin
            sw_nxt[via_pkg::SW_IE_BIT] = 1'b1;
        end
        else if (ACCEPT_OFF)
        begin
            sw_nxt[via_pkg::SW_IE_BIT] = 1'b0;
        end
        if (state_r == via_pkg::ST_PIP)
        begin
            sw_nxt[via_pkg::SW_IE_BIT] = 1'b0;                     // [R7] [R9] [R11]
            if (!is_brk_r)
            begin
                sw_nxt[via_pkg::SW_ISP_BIT] = sel_pr_r;            // [R7] [R15]
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            sw_r <= via_pkg::SW_RESET;                             // [R20]
        end
        else if (CE)
        begin
            sw_r <= sw_nxt;
        end
    end

    // ========================================================
    // servicing sequence: push status word, push pointer, vector
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state_r     <= via_pkg::ST_IDLE;
            is_brk_r    <= 1'b0;
            sel_r       <= '0;
            sel_pr_r    <= 1'b0;
            ip_r        <= '0;
            push_r      <= '0;
            vec_valid_r <= 1'b0;
            vec_addr_r  <= '0;
        end
        else if (CE)
        begin
            case (state_r)
                via_pkg::ST_IDLE:
                begin
                    vec_valid_r <= 1'b0;
                    if (start_any)
                    begin
                        state_r  <= via_pkg::ST_PSW;   // [R3] vector three clocks on
                        is_brk_r <= start_brk;
                        sel_r    <= sel;
                        sel_pr_r <= sel_pr;
                        ip_r     <= IP_IN;
                        // status word goes first, before accept is cleared
                        push_r   <= '{valid: 1'b1, is_ptr: 1'b0, data: {8'h00, sw_r}};
                    end
                end
                via_pkg::ST_PSW:
                begin
                    state_r <= via_pkg::ST_PIP;
                    push_r  <= '{valid: 1'b1, is_ptr: 1'b1, data: ip_r}; // [R7]
                end
                via_pkg::ST_PIP:
                begin
                    state_r     <= via_pkg::ST_VEC;
                    push_r      <= '0;
                    vec_valid_r <= 1'b1;
                    // one vector word per source, two addresses apart
                    vec_addr_r  <= is_brk_r ? via_pkg::BRK_VEC
                                 : via_pkg::VEC_BASE + {11'h000, sel_r, 1'b0}; // [R9] [R22]
                end
                default:
                begin
                    state_r     <= via_pkg::ST_IDLE;
                    vec_valid_r <= 1'b0;
                end
            endcase
        end
    end

    // ========================================================
    // ahb-lite slave, zero wait while CE is high, always okay
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            a_act_r <= 1'b0;
            a_wr_r  <= 1'b0;
            a_addr_r <= '0;
            rdata_r <= '0;
        end
        else if (CE && HREADY)
        begin
            a_act_r  <= HSEL && HTRANS == via_pkg::HTRANS_NSEQ;
            a_wr_r   <= HWRITE;
            a_addr_r <= HADDR[7:0];
            // read data fetched in the address phase; unmapped reads as zero
            if (HADDR[7:0] == via_pkg::OFS_REQ)
            begin
                rdata_r <= 32'(req_r);
            end
            else if (HADDR[7:0] == via_pkg::OFS_MASK)
            begin
                rdata_r <= 32'(mask_r);
            end
            else if (HADDR[7:0] == via_pkg::OFS_PRIO)
            begin
                rdata_r <= 32'(prio_r);
            end
            else if (HADDR[7:0] == via_pkg::OFS_SW)
            begin
                rdata_r <= {24'h000000, sw_r};
            end
            else if (HADDR[7:0] == via_pkg::OFS_STAT)
            begin
                rdata_r <= {16'h0000, 7'h00, is_brk_r, 6'h00, state_r} | 32'({sel_r, 8'h00});
            end
            else
            begin
                rdata_r <= '0;
            end
        end
    end

    // a bus access to the flag registers holds the next boundary
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            acc_hold_r <= 1'b0;
        end
        else if (CE)
        begin
            if (a_act_r && (a_addr_r == via_pkg::OFS_REQ || a_addr_r == via_pkg::OFS_MASK
                            || a_addr_r == via_pkg::OFS_PRIO))
            begin
                acc_hold_r <= 1'b1;                                // [R17]
            end
            else if (INSN_DONE)
            begin
                acc_hold_r <= 1'b0;
            end
        end
    end

    assign HREADYOUT    = CE;   // frozen state must not complete a transfer
    assign HRESP        = 1'b0;
    assign HRDATA       = rdata_r;
    assign SERVICE_BUSY = state_r != via_pkg::ST_IDLE;
    assign PUSH         = push_r;
    assign VEC_VALID    = vec_valid_r;
    assign VEC_ADDR     = vec_addr_r;
    assign STATUS_WORD  = sw_r;

    // ========================================================
    // checks
    elig_mask_a: assert property (@(posedge MCLK) disable iff (RST) // [R1]
        start_mask |-> req_r[sel] && !mask_r[sel])
        else $error("accepted a masked or idle source");
    accept_flag_a: assert property (@(posedge MCLK) disable iff (RST) // [R2]
        start_mask |-> sw_r[via_pkg::SW_IE_BIT])
        else $error("accepted with accept flag clear");
    div_wait_a: assert property (@(posedge MCLK) disable iff (RST) // [R4]
        DIV_BUSY |-> !start_mask)
        else $error("accepted during divide");
    level_pick_a: assert property (@(posedge MCLK) disable iff (RST) // [R5]
        start_mask && sel_pr |-> !(|(req_r & ~mask_r & ~prio_r)))
        else $error("low level chosen over high level");
    push_order_a: assert property (@(posedge MCLK) disable iff (RST || !CE) // [R7]
        start_any |=> PUSH.valid && !PUSH.is_ptr ##1 PUSH.valid && PUSH.is_ptr
        ##1 VEC_VALID && !PUSH.valid)
        else $error("push order wrong");
    brk_vec_a: assert property (@(posedge MCLK) disable iff (RST || !CE) // [R9]
        start_brk |-> ##3 VEC_ADDR == via_pkg::BRK_VEC && VEC_VALID)
        else $error("break vector wrong");
    accept_clear_a: assert property (@(posedge MCLK) disable iff (RST || !CE) // [R11]
        start_any |-> ##3 !sw_r[via_pkg::SW_IE_BIT])
        else $error("accept flag not cleared");
    nest_level_a: assert property (@(posedge MCLK) disable iff (RST) // [R12]
        start_mask && !sw_r[via_pkg::SW_ISP_BIT] |-> !prio_r[sel])
        else $error("low level nested in high servicing");
    isp_load_a: assert property (@(posedge MCLK) disable iff (RST || !CE) // [R15]
        start_mask |-> ##3 sw_r[via_pkg::SW_ISP_BIT] == $past(sel_pr, 3))
        else $error("level flag not loaded");
    hold_defer_a: assert property (@(posedge MCLK) disable iff (RST) // [R17]
        INSN_DONE && (INSN_HOLD || RETV_EXEC || BREAK_RETURN_INSTRUCTION_EXEC || ACCEPT_ON) |-> !start_mask)
        else $error("accepted after hold instruction");
    brk_block_a: assert property (@(posedge MCLK) disable iff (RST) // [R18]
        BRK_EXEC |-> !start_mask)
        else $error("maskable taken at break");
    req_set_a: assert property (@(posedge MCLK) disable iff (RST || !CE) // [R19]
        |IRQ_IN |=> (req_r & $past(IRQ_IN)) == $past(IRQ_IN))
        else $error("request pulse lost");
endmodule : via_core
`default_nettype wire

// *** via_cpu_model.sv ***
// behavioural cpu sequencer facing the acceptance block
`default_nettype none
module via_cpu_model
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // steering from the bench: next instruction kind, boundary spacing
    input  wire logic [3:0]         kind,
    input  wire logic [2:0]         gap,
    // from the acceptance block
    input  wire logic               busy,
    input  wire via_pkg::via_push_t push,
    input  wire logic               vec_valid,
    input  wire logic [15:0]        vec_addr,
    // boundary pulse and its attributes
    output logic                    done,
    output logic [7:0]              attr,
    output logic [7:0]              pop_data,
    output logic [15:0]             ip,
    output var int                  insn_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] stack_q[$];
    logic [2:0] wait_r;
    // ========================================================
    // boundaries only while the block is idle, at least gap+1 clocks apart, so two in a row when gap is 0
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            done     <= 1'b0;
            attr     <= 8'h00;
            pop_data <= 8'h02;
            ip       <= 16'h0100;
            insn_cnt <= 0;
            wait_r   <= 3'd1;
        end
        else
        begin
            done <= 1'b0;
            attr <= 8'h00;
            if (push.valid && !push.is_ptr)
                stack_q.push_back(push.data[7:0]);
            if (vec_valid)
                ip <= vec_addr;
            if (wait_r != 3'd0)
                wait_r <= wait_r - 3'd1;
            else if (!busy)
            begin
                done     <= 1'b1;
                wait_r   <= gap;
                ip       <= ip + 16'h1;
                insn_cnt <= insn_cnt + 1;
                // bit0 hold: every status, return and accept kind; break holds nothing
                attr     <= {kind == 4'd8, kind == 4'd7, kind == 4'd6, kind == 4'd5,
                             kind == 4'd4, kind == 4'd3, kind == 4'd2,
                             kind != 4'd0 && kind != 4'd4};
                if (kind inside {4'd5, 4'd6, 4'd7})
                    pop_data <= stack_q.size() > 0 ? stack_q.pop_back() : 8'h02;
            end
        end
    end
endmodule : via_cpu_model
`default_nettype wire

// *** vectored_interrupt_acceptance_tb.sv ***
// self-checking bench of the vectored interrupt acceptance block
`default_nettype none
module vectored_interrupt_acceptance_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================
    // stimulus and observation
    logic               mclk, rst, ce, hsel, hwrite, hready, hresp, insn_done, div_busy;
    logic               service_busy, vec_valid;
    logic [31:0]        haddr, hwdata, hrdata, seed;
    logic [1:0]         htrans;
    logic [2:0]         hsize, gap;
    logic [15:0]        irq, ip, vec_addr, last_vec;
    logic [7:0]         attr, pop_data, sw_load_data, status_word, last_psw;
    logic [3:0]         kind;
    via_pkg::via_push_t push;
    int                 insn_cnt, vec_insn, vec_cyc, fails, samples_checked;
    int                 vec_cnt = 0;
    int                 cycles = 0;

    via_core #(.N(16), .SW(4)) dut_u (.MCLK(mclk), .RST(rst), .CE(ce), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hready), .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp), .IRQ_IN(irq),
        .INSN_DONE(insn_done), .INSN_HOLD(attr[0]), .DIV_BUSY(div_busy), .BRK_EXEC(attr[3]),
        .RETV_EXEC(attr[4]), .BREAK_RETURN_INSTRUCTION_EXEC(attr[5]), .SW_POP(attr[6]), .POP_DATA(pop_data),
        .SW_LOAD(attr[7]), .SW_LOAD_DATA(sw_load_data), .ACCEPT_ON(attr[1]),
        .ACCEPT_OFF(attr[2]), .IP_IN(ip), .SERVICE_BUSY(service_busy), .PUSH(push),
        .VEC_VALID(vec_valid), .VEC_ADDR(vec_addr), .STATUS_WORD(status_word));
    via_cpu_model cpu_u (.clk(mclk), .rst(rst), .kind(kind), .gap(gap), .busy(service_busy),
        .push(push), .vec_valid(vec_valid), .vec_addr(vec_addr), .done(insn_done),
        .attr(attr), .pop_data(pop_data), .ip(ip), .insn_cnt(insn_cnt));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // ========================================================
    // capture vectors and pushed status words; cut a hang short
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (vec_valid === 1'b1)
        begin
            vec_cnt  <= vec_cnt + 1;
            last_vec <= vec_addr;
            vec_cyc  <= cycles;
            vec_insn <= insn_cnt;
        end
        if (push.valid === 1'b1 && push.is_ptr === 1'b0)
            last_psw <= push.data[7:0];
        if (cycles == 20000)
        begin
            fails = fails + 1;
            conclude();
        end
    end
    // ========================================================
    // helpers
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // high level first, then lowest index; low level only outside high service
    function automatic logic [15:0] exp_vec(input logic [15:0] r, m, p, input logic in_service_level_flag);
        for (int i = 0; i < 16; i++)
            if (r[i] && !m[i] && !p[i]) return via_pkg::VEC_BASE + 16'(2 * i);
        for (int i = 0; i < 16; i++)
            if (r[i] && !m[i] && in_service_level_flag) return via_pkg::VEC_BASE + 16'(2 * i);
        return 16'hffff;
    endfunction : exp_vec
    // one single ahb transfer; the address phase holds until hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= via_pkg::HTRANS_NSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask : wreg
    // run one instruction of the given kind; returns one edge after the block
    // took its boundary, so a restored or loaded status word has landed
    task automatic insn(input logic [3:0] k);
        @(posedge mclk);
        kind <= k;
        @(posedge mclk);
        do @(posedge mclk); while (insn_done !== 1'b1);
        kind <= 4'd0;
        @(posedge mclk);
    endtask : insn
    task automatic pulse(input logic [15:0] m);
        @(posedge mclk);
        irq <= m;
        @(posedge mclk);
        irq <= 16'h0;
    endtask : pulse
    // vector, then two edges so the status word update has landed
    task automatic wait_vec(input int c);
        for (int i = 0; i < 80 && vec_cnt == c; i++) @(posedge mclk);
        repeat (2) @(posedge mclk);
    endtask : wait_vec
    // ========================================================
    // main sequence
    initial
    begin
        logic [31:0] r, m, p, d;
        logic [15:0] ev;
        int          c, w;
        {rst, ce, hsel, hwrite, div_busy} = 5'b11000;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        {irq, sw_load_data, kind, gap} = {16'h0, 8'h0, 4'h0, 3'd1};
        {fails, samples_checked, seed} = {32'd0, 32'd0, 32'hcf7ab95e};
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        chk(32'(status_word), 32'(via_pkg::SW_RESET));
        bus(1'b0, 8'h40, 32'h0, d);
        chk(d, 32'h0);
        chk(32'(hresp), 32'h0);
        $display("test reset done");
        // random arbitration among simultaneous requests
        for (int it = 0; it < 8; it++)
        begin
            insn(4'd3);
            w = int'(rnd() % 16);
            m = rnd() & ~(32'h1 << w) & 32'hffff;
            p = rnd() & 32'hffff;
            r = (rnd() | (32'h1 << w)) & 32'hffff;
            wreg(via_pkg::OFS_MASK, m);
            wreg(via_pkg::OFS_PRIO, p);
            wreg(via_pkg::OFS_REQ, 32'h0);
            c = vec_cnt;
            pulse(r[15:0]);
            bus(1'b0, via_pkg::OFS_REQ, 32'h0, d);
            chk(d, r);
            chk(32'(vec_cnt), 32'(c));
            insn(4'd2);
            wait_vec(c);
            ev = exp_vec(r[15:0], m[15:0], p[15:0], 1'b1);
            chk(32'(last_vec), 32'(ev));
            chk(32'(last_psw), 32'h82);
            chk(32'(status_word), {30'h0, p[(ev - 16'h4) >> 1], 1'b0});
            wreg(via_pkg::OFS_REQ, 32'h0);
            insn(4'd5);
            chk(32'(status_word), 32'h82);
        end
        $display("test arbitration done");
        // latency with a slow sequencer: source 0 high, 1 low, 2 high
        insn(4'd3);
        wreg(via_pkg::OFS_MASK, 32'hfff8);
        wreg(via_pkg::OFS_PRIO, 32'hfffa);
        insn(4'd2);
        gap <= 3'd3;
        c = vec_cnt;
        w = cycles;
        pulse(16'h0001);
        wait_vec(c);
        chk(32'(vec_cyc - w <= via_pkg::LAT_HI_MAX), 32'h1);
        chk(32'(status_word), 32'h00);
        gap <= 3'd1;
        $display("test latency done");
        // nesting in high service: low waits, high nests, break always
        insn(4'd2);
        c = vec_cnt;
        pulse(16'h0002);
        repeat (40) @(posedge mclk);
        chk(32'(vec_cnt), 32'(c));
        pulse(16'h0004);
        wait_vec(c);
        chk(32'(last_vec), 32'h0008);
        chk(32'(status_word), 32'h00);
        c = vec_cnt;
        insn(4'd4);
        wait_vec(c);
        chk(32'(last_vec), 32'(via_pkg::BRK_VEC));
        chk(32'(last_psw), 32'h00);
        insn(4'd6);
        insn(4'd5);
        chk(32'(status_word), 32'h80);
        c = vec_cnt;
        insn(4'd5);
        w = insn_cnt;
        wait_vec(c);
        chk(32'(last_vec), 32'h0006);
        chk(32'(vec_insn > w), 32'h1);
        $display("test nesting done");
        // a running divide holds acceptance back
        insn(4'd5);
        div_busy <= 1'b1;
        c = vec_cnt;
        pulse(16'h0001);
        repeat (40) @(posedge mclk);
        chk(32'(vec_cnt), 32'(c));
        div_busy <= 1'b0;
        wait_vec(c);
        chk(32'(last_vec), 32'h0004);
        // status pop and load; with the flag cleared a request waits
        insn(4'd7);
        chk(32'(status_word), 32'h82);
        sw_load_data <= 8'h02;
        insn(4'd8);
        c = vec_cnt;
        pulse(16'h0004);
        repeat (40) @(posedge mclk);
        chk(32'(vec_cnt), 32'(c));
        chk(32'(status_word), 32'h02);
        $display("test divide and load done");
        conclude();
    end
endmodule : vectored_interrupt_acceptance_tb
`default_nettype wire
